// [split_timer_pkg.sv]
// Constants and carrier types shared by the split reload timer files.
package split_timer_pkg;

	// ********************************
	// Register addresses
	// ********************************
	localparam logic [7:0] ADDR_CONTROL     = 8'hc8;
	localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hcd;

	// ********************************
	// Field positions of the control register
	// ********************************
	localparam int BIT_HIGH_FLAG   = 7;
	localparam int BIT_LOW_FLAG    = 6;
	localparam int BIT_LOW_IRQ_EN  = 5;
	localparam int BIT_CAPTURE_EN  = 4;
	localparam int BIT_SPLIT       = 3;
	localparam int BIT_RUN         = 2;
	localparam int BIT_CAPTURE_SRC = 1;
	localparam int BIT_EXT_CLOCK   = 0;

	// ********************************
	// Reset values and counting limits
	// ********************************
	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [7:0]  BYTE_MAX    = 8'hff;
	localparam logic [15:0] COUNT_MAX   = 16'hffff;
	localparam logic [7:0]  RESET_RDATA = 8'h00;

	// ********************************
	// Prescaler ratios
	// ********************************
	localparam int CORE_DIV = 12;
	localparam int EXT_DIV  = 8;

	// Control register layout, bit 7 first.
	typedef struct packed {
		logic high_overflow_flag;
		logic low_overflow_flag;
		logic low_irq_enable;
		logic osc_capture_enable;
		logic split_mode_enable;
		logic run_control;
		logic capture_source_select;
		logic ext_clock_select;
	} timer_ctrl_t;

	localparam timer_ctrl_t RESET_CTRL = timer_ctrl_t'(8'h00);

	// One register access from the core.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
	} sfr_req_t;

endpackage : split_timer_pkg

// [timer_ticks.sv]
// Prescalers for the timer and the oscillator falling-edge detector.
module timer_ticks
	import split_timer_pkg::*;
#(
	parameter int CORE_RATIO = CORE_DIV,
	parameter int EXT_RATIO  = EXT_DIV
) (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic ext_clock,
	input  wire logic low_freq_oscillator,
	output logic      core_div_tick,
	output logic      ext_div_tick,
	output logic      capture_strobe
);

	// Both ratios must fit the counters below.
	if (CORE_RATIO < 2 || CORE_RATIO > 256 || EXT_RATIO < 2 || EXT_RATIO > 256) begin : g_chk
		$error("timer_ticks: ratios must lie in 2..256");
	end

	localparam logic [7:0] CORE_LAST = 8'(CORE_RATIO - 1);
	localparam logic [7:0] EXT_LAST  = 8'(EXT_RATIO - 1);

	logic [7:0] core_cnt_q, core_cnt_d;
	logic [7:0] ext_cnt_q, ext_cnt_d;
	logic       ext_prev_q, ext_prev_d;
	logic       core_tick_q, core_tick_d;
	logic       ext_tick_q, ext_tick_d;
	logic       lfo_meta_q, lfo_sync_q, lfo_prev_q;
	logic       strobe_q, strobe_d;

	// ********************************
	// Prescaler counters
	// ********************************

	// The core divider ticks once per ratio; the external divider counts rising edges.
	always_comb begin
		core_tick_d = (core_cnt_q == CORE_LAST);
		core_cnt_d  = core_tick_d ? 8'h00 : core_cnt_q + 8'h01;
		ext_prev_d  = ext_clock;
		ext_tick_d  = 1'b0;
		ext_cnt_d   = ext_cnt_q;
		if (ext_clock && !ext_prev_q) begin
			ext_tick_d = (ext_cnt_q == EXT_LAST);
			ext_cnt_d  = ext_tick_d ? 8'h00 : ext_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			core_cnt_q  <= 8'h00;
			ext_cnt_q   <= 8'h00;
			ext_prev_q  <= 1'b0;
			core_tick_q <= 1'b0;
			ext_tick_q  <= 1'b0;
		end else begin
			core_cnt_q  <= core_cnt_d;
			ext_cnt_q   <= ext_cnt_d;
			ext_prev_q  <= ext_prev_d;
			core_tick_q <= core_tick_d;
			ext_tick_q  <= ext_tick_d;
		end
	end

	// ********************************
	// Oscillator synchroniser and edge
	// ********************************

	// Only the second stage and its delayed copy feed the edge detector.
	always_comb begin
		strobe_d = lfo_prev_q && !lfo_sync_q;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lfo_meta_q <= 1'b0;
			lfo_sync_q <= 1'b0;
			lfo_prev_q <= 1'b0;
			strobe_q   <= 1'b0;
		end else begin
			lfo_meta_q <= low_freq_oscillator;
			lfo_sync_q <= lfo_meta_q;
			lfo_prev_q <= lfo_sync_q;
			strobe_q   <= strobe_d;
		end
	end

	assign core_div_tick  = core_tick_q;
	assign ext_div_tick   = ext_tick_q;
	assign capture_strobe = strobe_q;

endmodule : timer_ticks

// [split_reload_timer.sv]
// Split or 16-bit auto-reload timer with oscillator capture and register port.

// Operation
// - Control bit 4 set turns on oscillator capture mode.
// - Each oscillator falling edge copies the 16-bit count into the reload bytes.
// - Capture with interrupts enabled requests an interrupt on each falling edge.
// - Control bit 3 set splits into two 8-bit auto-reload counters.
// - Control bit 2 runs or stops the counter in 16-bit mode.
// - In split mode run gates only the high half; low half always counts.
// - Control bit 1 selects capture source; one is the oscillator, zero reserved.
// - Control bit 0 picks core clock over 12 or external clock over 8.
// - Per-half fast select picks full core clock or the bit 0 choice; in 16-bit mode only the low one acts.
// - Address 0xca holds reload low byte, reset zero.
// - Address 0xcb holds reload high byte, reset zero.
// - Address 0xcc reads and writes the low count byte.
// - 16-bit overflow loads reload value and sets the high overflow flag.
// - Low byte wrap sets the low overflow flag; software clears both flags.
module split_reload_timer
	import split_timer_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire sfr_req_t   sfr_req,
	output logic [7:0]      sfr_rdata,
	input  wire logic       timer_irq_enable,
	input  wire logic       high_half_fast_clock_select,
	input  wire logic       low_half_fast_clock_select,
	input  wire logic       ext_clock,
	input  wire logic       low_freq_oscillator,
	output logic            timer_irq
);

	timer_ctrl_t ctrl_q, ctrl_d;
	logic [7:0]  reload_lo_q, reload_lo_d;
	logic [7:0]  reload_hi_q, reload_hi_d;
	logic [7:0]  count_lo_q, count_lo_d;
	logic [7:0]  count_hi_q, count_hi_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        irq_q, irq_d;
	logic        core_div_tick;
	logic        ext_div_tick;
	logic        capture_strobe;
	logic        slow_tick;
	logic        tick_lo;
	logic        tick_hi;
	logic        capture_hit;
	logic        wrap_lo;
	logic        wrap_hi;
	logic        wr_ctrl;
	logic        wr_reload_lo;
	logic        wr_reload_hi;
	logic        wr_count_lo;
	logic        wr_count_hi;
	logic        flag_req;

	// ********************************
	// Helper functions and layout check
	// ********************************

	// Every control field must sit on its own bit of the byte, or reads would alias.
	localparam logic [7:0] FIELD_MASK = (8'h01 << BIT_HIGH_FLAG) | (8'h01 << BIT_LOW_FLAG)
		| (8'h01 << BIT_LOW_IRQ_EN) | (8'h01 << BIT_CAPTURE_EN) | (8'h01 << BIT_SPLIT)
		| (8'h01 << BIT_RUN) | (8'h01 << BIT_CAPTURE_SRC) | (8'h01 << BIT_EXT_CLOCK);

	if (FIELD_MASK != 8'hff || $bits(timer_ctrl_t) != 8) begin : g_layout_chk
		$error("split_reload_timer: control fields must fill one byte exactly");
	end

	// Returns true when a write targets the given address.
	function automatic logic wr_hit(input sfr_req_t req, input logic [7:0] addr);
		return req.wr && (req.addr == addr);
	endfunction : wr_hit

	// Advances one 8-bit half; the top bit of the result flags a wrap.
	// A wrap restarts from the reload byte, not from zero, so no tick is lost.
	function automatic logic [8:0] step_byte(input logic [7:0] value, input logic [7:0] reload);
		logic [8:0] result;
		if (value == BYTE_MAX) begin
			result = {1'b1, reload};
		end else begin
			result = {1'b0, value + 8'h01};
		end
		return result;
	endfunction : step_byte

	// Builds the control fields from a written byte, each from its fixed position.
	function automatic timer_ctrl_t unpack_ctrl(input logic [7:0] data);
		timer_ctrl_t ctrl;
		ctrl.high_overflow_flag    = data[BIT_HIGH_FLAG];
		ctrl.low_overflow_flag     = data[BIT_LOW_FLAG];
		ctrl.low_irq_enable        = data[BIT_LOW_IRQ_EN];
		ctrl.osc_capture_enable    = data[BIT_CAPTURE_EN];
		ctrl.split_mode_enable     = data[BIT_SPLIT];
		ctrl.run_control           = data[BIT_RUN];
		ctrl.capture_source_select = data[BIT_CAPTURE_SRC];
		ctrl.ext_clock_select      = data[BIT_EXT_CLOCK];
		return ctrl;
	endfunction : unpack_ctrl

	// Lays the control fields out as software reads them.
	function automatic logic [7:0] pack_ctrl(input timer_ctrl_t ctrl);
		logic [7:0] data;
		data                  = 8'h00;
		data[BIT_HIGH_FLAG]   = ctrl.high_overflow_flag;
		data[BIT_LOW_FLAG]    = ctrl.low_overflow_flag;
		data[BIT_LOW_IRQ_EN]  = ctrl.low_irq_enable;
		data[BIT_CAPTURE_EN]  = ctrl.osc_capture_enable;
		data[BIT_SPLIT]       = ctrl.split_mode_enable;
		data[BIT_RUN]         = ctrl.run_control;
		data[BIT_CAPTURE_SRC] = ctrl.capture_source_select;
		data[BIT_EXT_CLOCK]   = ctrl.ext_clock_select;
		return data;
	endfunction : pack_ctrl

	// ********************************
	// Register write decode
	// ********************************

	// One strobe per register, decoded once for all the next-state processes.
	always_comb begin
		wr_ctrl      = wr_hit(sfr_req, ADDR_CONTROL);
		wr_reload_lo = wr_hit(sfr_req, ADDR_RELOAD_LOW);
		wr_reload_hi = wr_hit(sfr_req, ADDR_RELOAD_HIGH);
		wr_count_lo  = wr_hit(sfr_req, ADDR_COUNT_LOW);
		wr_count_hi  = wr_hit(sfr_req, ADDR_COUNT_HIGH);
	end

	// ********************************
	// Clock sources
	// ********************************

	// Prescalers and the oscillator edge strobe.
	timer_ticks #(
		.CORE_RATIO (CORE_DIV),
		.EXT_RATIO  (EXT_DIV)
	) u_ticks (
		.mclk                (mclk),
		.reset_n             (reset_n),
		.ext_clock           (ext_clock),
		.low_freq_oscillator (low_freq_oscillator),
		.core_div_tick       (core_div_tick),
		.ext_div_tick        (ext_div_tick),
		.capture_strobe      (capture_strobe)
	);

	// In split mode each half counts on the full clock or the prescaled choice; 16-bit mode counts on tick_lo alone.
	always_comb begin
		slow_tick = ctrl_q.ext_clock_select ? ext_div_tick : core_div_tick;
		tick_lo   = low_half_fast_clock_select ? 1'b1 : slow_tick;
		tick_hi   = high_half_fast_clock_select ? 1'b1 : slow_tick;
	end

	// Capture needs the enable and the oscillator source; zero is reserved and inert.
	always_comb begin
		capture_hit = capture_strobe && ctrl_q.osc_capture_enable
			&& ctrl_q.capture_source_select;
	end

	// ********************************
	// Counter
	// ********************************

	// Counting, reloading and software writes of the count bytes.
	always_comb begin
		count_lo_d = count_lo_q;
		count_hi_d = count_hi_q;
		wrap_lo    = 1'b0;
		wrap_hi    = 1'b0;
		if (ctrl_q.split_mode_enable) begin
			// Low half runs regardless of the run bit.
			if (tick_lo) begin
				{wrap_lo, count_lo_d} = step_byte(count_lo_q, reload_lo_q);
			end
			if (ctrl_q.run_control && tick_hi) begin
				{wrap_hi, count_hi_d} = step_byte(count_hi_q, reload_hi_q);
			end
		end else if (ctrl_q.run_control && tick_lo) begin
			if ({count_hi_q, count_lo_q} == COUNT_MAX) begin
				count_hi_d = reload_hi_q;
				count_lo_d = reload_lo_q;
				wrap_hi    = 1'b1;
				wrap_lo    = 1'b1;
			end else begin
				{count_hi_d, count_lo_d} = {count_hi_q, count_lo_q} + 16'h0001;
				wrap_lo = (count_lo_q == BYTE_MAX);
			end
		end
		// A software write replaces the byte it targets.
		if (wr_count_lo) begin
			count_lo_d = sfr_req.wdata;
		end
		if (wr_count_hi) begin
			count_hi_d = sfr_req.wdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_lo_q <= RESET_BYTE;
			count_hi_q <= RESET_BYTE;
		end else begin
			count_lo_q <= count_lo_d;
			count_hi_q <= count_hi_d;
		end
	end

	// ********************************
	// Reload bytes
	// ********************************

	// A capture latches the live count; a software write in the same cycle wins.
	always_comb begin
		reload_lo_d = reload_lo_q;
		reload_hi_d = reload_hi_q;
		if (capture_hit) begin
			reload_lo_d = count_lo_q;
			reload_hi_d = count_hi_q;
		end
		if (wr_reload_lo) begin
			reload_lo_d = sfr_req.wdata;
		end
		if (wr_reload_hi) begin
			reload_hi_d = sfr_req.wdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reload_lo_q <= RESET_BYTE;
			reload_hi_q <= RESET_BYTE;
		end else begin
			reload_lo_q <= reload_lo_d;
			reload_hi_q <= reload_hi_d;
		end
	end

	// ********************************
	// Control register
	// ********************************

	// Software writes every bit; an overflow in the same cycle wins over a clear.
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = unpack_ctrl(sfr_req.wdata);
		end
		if (wrap_hi) begin
			ctrl_d.high_overflow_flag = 1'b1;
		end
		if (wrap_lo) begin
			ctrl_d.low_overflow_flag = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= RESET_CTRL;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ********************************
	// Interrupt request and read data
	// ********************************

	// Flag request looks at the next flag values so the request rises with the flag.
	always_comb begin
		flag_req = ctrl_d.high_overflow_flag
			|| (ctrl_d.low_irq_enable && ctrl_d.low_overflow_flag);
	end

	// Request stands while an enabled flag is set, and pulses on each capture.
	always_comb begin
		irq_d = timer_irq_enable && (flag_req || capture_hit);
	end

	// Read data follows the address one cycle later; unmapped reads give zero.
	always_comb begin
		unique case (sfr_req.addr)
			ADDR_CONTROL:     rdata_d = pack_ctrl(ctrl_q);
			ADDR_RELOAD_LOW:  rdata_d = reload_lo_q;
			ADDR_RELOAD_HIGH: rdata_d = reload_hi_q;
			ADDR_COUNT_LOW:   rdata_d = count_lo_q;
			ADDR_COUNT_HIGH:  rdata_d = count_hi_q;
			default:          rdata_d = RESET_RDATA;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_q   <= 1'b0;
			rdata_q <= RESET_RDATA;
		end else begin
			irq_q   <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign timer_irq = irq_q;

endmodule : split_reload_timer

// [split_reload_timer_asserts.sv]
// Checker of the split reload timer port behaviour.
module split_reload_timer_asserts
	import split_timer_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire sfr_req_t   sfr_req,
	input  wire logic [7:0] sfr_rdata,
	input  wire logic       timer_irq_enable,
	input  wire logic       high_half_fast_clock_select,
	input  wire logic       low_half_fast_clock_select,
	input  wire logic       ext_clock,
	input  wire logic       low_freq_oscillator,
	input  wire logic       timer_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] cap_q;

	// Mirrors the capture enable and source bits as the core writes them.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cap_q <= 2'h0;
		end else if (sfr_req.wr && sfr_req.addr == ADDR_CONTROL) begin
			cap_q <= {sfr_req.wdata[BIT_CAPTURE_EN], sfr_req.wdata[BIT_CAPTURE_SRC]};
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// A written byte reads back on the next access to the same place.
	property wr_rd(a, m);
		sfr_req.wr && sfr_req.addr == a ##1 sfr_req.addr == a
			|=> (sfr_rdata & m) == ($past(sfr_req.wdata, 2) & m);
	endproperty

	rl_low_rw_a: assert property (wr_rd(ADDR_RELOAD_LOW, 8'hff))
		else $error("reload low readback wrong");
	rl_high_rw_a: assert property (wr_rd(ADDR_RELOAD_HIGH, 8'hff))
		else $error("reload high readback wrong");
	cnt_low_rw_a: assert property (wr_rd(ADDR_COUNT_LOW, 8'hff))
		else $error("count low readback wrong");
	ctrl_rw_a: assert property (wr_rd(ADDR_CONTROL, 8'h3f))
		else $error("control readback wrong");
	unmapped_zero_a: assert property (sfr_req.addr == 8'hc9 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	flags_sticky_a: assert property ((sfr_req.addr == ADDR_CONTROL && !sfr_req.wr) ##1
		sfr_req.addr == ADDR_CONTROL |=> (sfr_rdata[7:6] & $past(sfr_rdata[7:6]))
		== $past(sfr_rdata[7:6]))
		else $error("overflow flag cleared by hardware");
	irq_gate_a: assert property (!timer_irq_enable |=> !timer_irq)
		else $error("interrupt while disabled");
	capture_irq_a: assert property ($fell(low_freq_oscillator) && cap_q == 2'h3 &&
		timer_irq_enable |-> ##[1:7] timer_irq)
		else $error("no interrupt after capture edge");

	cover property (sfr_req.addr == ADDR_CONTROL ##1 sfr_rdata[7]);
	cover property ($fell(low_freq_oscillator) && cap_q == 2'h3);
	cover property (timer_irq);
	cover property (sfr_req.addr == ADDR_CONTROL ##1 sfr_rdata[6]);
endmodule : split_reload_timer_asserts

bind split_reload_timer split_reload_timer_asserts i_chk (.mclk(mclk), .reset_n(reset_n),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
	.high_half_fast_clock_select(high_half_fast_clock_select),
	.low_half_fast_clock_select(low_half_fast_clock_select), .ext_clock(ext_clock),
	.low_freq_oscillator(low_freq_oscillator), .timer_irq(timer_irq));

// [sfr_core_model.sv]
// Processor core model issuing register accesses.
module sfr_core_model
	import split_timer_pkg::*;
(
	input  wire logic       mclk,
	output sfr_req_t        sfr_req,
	input  wire logic [7:0] sfr_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// The core starts idle with the strobe low.
	initial sfr_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0};

	// Writes one byte; the strobe stands for one edge, then the data is spoilt.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_req <= '{addr: a, wdata: d, wr: 1'b1};
		@(negedge mclk);
		sfr_req.wr <= 1'b0;
		sfr_req.wdata <= ~d;
	endtask : write_reg

	// Reads one byte; data follows one edge after the address edge.
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		sfr_req.addr <= a;
		@(negedge mclk);
		d = sfr_rdata;
	endtask : read_reg
endmodule : sfr_core_model

// [test_split_reload_timer.sv]
// Self-checking bench of the split reload timer.
module test_split_reload_timer import split_timer_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk = 1'b0;
	logic       reset_n = 1'b0;
	sfr_req_t   sfr_req;
	logic [7:0] sfr_rdata;
	logic       irq_en = 1'b0;
	logic       hi_fast = 1'b0;
	logic       lo_fast = 1'b1;
	logic       ext_clock = 1'b0;
	logic       osc = 1'b1;
	logic       timer_irq;
	int         err_count = 0;
	int         n_compared = 0;

	// Clock and an external clock rising every second cycle.
	always #12.5 mclk = ~mclk;
	always @(negedge mclk) ext_clock <= ~ext_clock;

	split_reload_timer i_dut (.mclk(mclk), .reset_n(reset_n), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .timer_irq_enable(irq_en), .high_half_fast_clock_select(hi_fast),
		.low_half_fast_clock_select(lo_fast), .ext_clock(ext_clock),
		.low_freq_oscillator(osc), .timer_irq(timer_irq));
	sfr_core_model i_core (.mclk(mclk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

	// ****
	// Checking tasks
	// ****
	task automatic finish_test();
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task automatic check_range(input logic [7:0] got, lo, hi);
		n_compared++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask : check_range

	task automatic check_bit(input logic got, exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_bit

	task automatic expect_reg(input logic [7:0] a, lo, hi);
		logic [7:0] d;
		i_core.read_reg(a, d);
		check_range(d, lo, hi);
	endtask : expect_reg

	// ****
	// Scenarios
	// ****
	task automatic test_rw();
		expect_reg(ADDR_RELOAD_LOW, RESET_BYTE, RESET_BYTE);
		expect_reg(ADDR_RELOAD_HIGH, RESET_BYTE, RESET_BYTE);
		i_core.write_reg(ADDR_RELOAD_LOW, 8'h5a);
		i_core.write_reg(ADDR_RELOAD_HIGH, 8'ha5);
		i_core.write_reg(8'hc9, 8'hff);
		expect_reg(ADDR_RELOAD_LOW, 8'h5a, 8'h5a);
		expect_reg(ADDR_RELOAD_HIGH, 8'ha5, 8'ha5);
		i_core.write_reg(ADDR_COUNT_LOW, 8'h3c);
		expect_reg(ADDR_COUNT_LOW, 8'h3c, 8'h3c);
		repeat (20) @(negedge mclk);
		expect_reg(ADDR_COUNT_LOW, 8'h3c, 8'h3c);
		expect_reg(8'hc9, 8'h00, 8'h00);
	endtask : test_rw

	task automatic test_overflow();
		irq_en = 1'b1;
		i_core.write_reg(ADDR_RELOAD_LOW, 8'h34);
		i_core.write_reg(ADDR_RELOAD_HIGH, 8'h12);
		i_core.write_reg(ADDR_COUNT_HIGH, 8'hff);
		i_core.write_reg(ADDR_COUNT_LOW, 8'hf8);
		check_bit(timer_irq, 1'b0);
		i_core.write_reg(ADDR_CONTROL, 8'h04);
		repeat (12) @(negedge mclk);
		expect_reg(ADDR_CONTROL, 8'hc4, 8'hc4);
		expect_reg(ADDR_COUNT_HIGH, 8'h12, 8'h12);
		check_bit(timer_irq, 1'b1);
		i_core.write_reg(ADDR_CONTROL, 8'h00);
		expect_reg(ADDR_CONTROL, 8'h00, 8'h00);
		check_bit(timer_irq, 1'b0);
	endtask : test_overflow

	task automatic test_split();
		hi_fast = 1'b1;
		i_core.write_reg(ADDR_RELOAD_LOW, 8'hf0);
		i_core.write_reg(ADDR_COUNT_HIGH, 8'h77);
		i_core.write_reg(ADDR_COUNT_LOW, 8'hfc);
		i_core.write_reg(ADDR_CONTROL, 8'h08);
		repeat (10) @(negedge mclk);
		expect_reg(ADDR_CONTROL, 8'h48, 8'h48);
		expect_reg(ADDR_COUNT_HIGH, 8'h77, 8'h77);
		expect_reg(ADDR_COUNT_LOW, 8'hf0, 8'hff);
		i_core.write_reg(ADDR_CONTROL, 8'h0c);
		repeat (10) @(negedge mclk);
		expect_reg(ADDR_COUNT_HIGH, 8'h78, 8'h90);
		hi_fast = 1'b0;
	endtask : test_split

	task automatic test_prescale();
		lo_fast = 1'b0;
		for (int i = 0; i < 2; i++) begin
			i_core.write_reg(ADDR_CONTROL, 8'h00);
			i_core.write_reg(ADDR_COUNT_HIGH, 8'h00);
			i_core.write_reg(ADDR_COUNT_LOW, 8'h00);
			i_core.write_reg(ADDR_CONTROL, 8'h04 | 8'(i));
			repeat (10 * ((i == 0) ? CORE_DIV : EXT_DIV * 2)) @(negedge mclk);
			expect_reg(ADDR_COUNT_LOW, 8'h08, 8'h0b);
		end
		lo_fast = 1'b1;
	endtask : test_prescale

	task automatic test_capture();
		int n;
		i_core.write_reg(ADDR_CONTROL, 8'h00);
		i_core.write_reg(ADDR_COUNT_HIGH, 8'h50);
		i_core.write_reg(ADDR_COUNT_LOW, 8'h00);
		i_core.write_reg(ADDR_CONTROL, 8'h16);
		osc = 1'b0;
		for (n = 0; n < 8 && timer_irq !== 1'b1; n++)
			@(negedge mclk);
		check_bit(timer_irq, 1'b1);
		if (timer_irq !== 1'b1)
			finish_test();
		@(negedge mclk);
		check_bit(timer_irq, 1'b0);
		expect_reg(ADDR_RELOAD_HIGH, 8'h50, 8'h50);
		expect_reg(ADDR_RELOAD_LOW, 8'h01, 8'h20);
		osc = 1'b1;
	endtask : test_capture

	task automatic test_low_irq();
		i_core.write_reg(ADDR_CONTROL, 8'h00);
		i_core.write_reg(ADDR_RELOAD_LOW, 8'hf0);
		i_core.write_reg(ADDR_COUNT_LOW, 8'hf0);
		i_core.write_reg(ADDR_CONTROL, 8'h18);
		osc = 1'b0;
		repeat (20) @(negedge mclk);
		check_bit(timer_irq, 1'b0);
		expect_reg(ADDR_RELOAD_LOW, 8'hf0, 8'hf0);
		expect_reg(ADDR_CONTROL, 8'h58, 8'h58);
		osc = 1'b1;
		i_core.write_reg(ADDR_CONTROL, 8'h28);
		repeat (20) @(negedge mclk);
		check_bit(timer_irq, 1'b1);
		irq_en = 1'b0;
	endtask : test_low_irq

	// Main sequence: reset, then every scenario once.
	initial begin
		repeat (8) @(negedge mclk);
		reset_n = 1'b1;
		test_rw();
		test_overflow();
		test_split();
		test_prescale();
		test_capture();
		test_low_irq();
		finish_test();
	end
endmodule : test_split_reload_timer
